// *** hdl/gpfr_pkg.sv ***
// Constants for the pin function and reset-out block
package gpfr_pkg;
  localparam int PIN_COUNT = 8;
  localparam int LIRQ_COUNT = 4;
  localparam int RST_PIN_IDX = 4;
  localparam int RST_STRETCH_CYCLES = 512;
  localparam int CLK_FREQ_MHZ = 10;
  localparam int PLL_LOCK_TIME_US = 100;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_TIME_US * CLK_FREQ_MHZ;
  localparam int DEFAULT_VCO_RATIO = 4;
  localparam int STRETCH_W = 16;
  localparam int DIV_W = 4;
  localparam int BUS_CLK_DIV = 2;
  localparam int REF_CLK_DIV = 4;
  localparam logic [7:0] RST_PORTC_OE = 8'h10;
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_GPIO = 3'h0;
  localparam logic [2:0] SEL_SERIAL = 3'h1;
  localparam logic [2:0] SEL_DMA = 3'h2;
  localparam logic [2:0] SEL_CAM = 3'h3;
  localparam logic [2:0] SEL_DRAM = 3'h4;
  localparam logic [2:0] SEL_IRQ = 3'h5;
  localparam logic [2:0] SEL_RESET = 3'h6;
  typedef enum logic [1:0] {MODE_FUNCTIONAL, MODE_PLL_TEST, MODE_SELFTEST, MODE_SCAN} gpfr_mode_type;
endpackage

// *** hdl/gpfr_sync3.sv ***
// Three-flop synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module gpfr_sync3
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      meta_q <= asyncIn;
      s2_q <= meta_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        syncOut <= s3_q; // see [R6] see [R11]
    end
  end
endmodule
`default_nettype wire

// *** hdl/gpfr_pin_mux.sv ***
// Port pin function selection, level interrupts and stretched reset output
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [R1] Reset-out stretched 512 cycles, PLL off
// [R2] PLL on: stretch 100 us times ratio
// [R3] Reset pin is driven output after reset
// [R4] Reset-out shows chip reset state
// [R5] Port C pins 3..0 are level interrupts
// [R6] Interrupt inputs are asynchronous to clocks
// [R7] Interrupt follows input level, not software
// [R8] Three clock domains exist in device
// [R9] Three active-low straps select chip mode
// [R10] Each pin routes GPIO or one alternate
// [R11] Interrupt inputs synchronised before use
module gpfr_pin_mux #(
  parameter int PIN_W = gpfr_pkg::PIN_COUNT,
  parameter int STRETCH_COUNT = gpfr_pkg::RST_STRETCH_CYCLES,
  parameter int VCO_RATIO = gpfr_pkg::DEFAULT_VCO_RATIO,
  parameter int PLL_LOCK_COUNT = gpfr_pkg::PLL_LOCK_CYCLES * VCO_RATIO
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pllEnable,
  input wire logic pll_test_strap_n,
  input wire logic selftest_strap_n,
  input wire logic scan_strap_n,
  input wire logic [PIN_W*gpfr_pkg::SEL_W-1:0] portASel,
  input wire logic [PIN_W*gpfr_pkg::SEL_W-1:0] portCSel,
  input wire logic [PIN_W-1:0] portAGpioOut,
  input wire logic [PIN_W-1:0] portAGpioOe,
  input wire logic [PIN_W-1:0] portAAltOut,
  input wire logic [PIN_W-1:0] portAAltOe,
  input wire logic [PIN_W-1:0] portCGpioOut,
  input wire logic [PIN_W-1:0] portCGpioOe,
  input wire logic [PIN_W-1:0] portCAltOut,
  input wire logic [PIN_W-1:0] portCAltOe,
  input wire logic [PIN_W-1:0] portAPinIn,
  input wire logic [PIN_W-1:0] portCPinIn,
  output logic [PIN_W-1:0] portAPinOut,
  output logic [PIN_W-1:0] portAPinOe,
  output logic [PIN_W-1:0] portCPinOut,
  output logic [PIN_W-1:0] portCPinOe,
  output logic [PIN_W-1:0] portAIn,
  output logic [PIN_W-1:0] portCIn,
  output logic [gpfr_pkg::LIRQ_COUNT-1:0] level_irq_pins,
  output logic chipInReset,
  output logic [1:0] chipMode,
  output logic busTick,
  output logic refTick
);
  logic [PIN_W-1:0] portASync;
  logic [PIN_W-1:0] portCSync;
  logic [gpfr_pkg::STRETCH_W-1:0] stretch_q;
  logic [gpfr_pkg::STRETCH_W-1:0] stretch_d;
  logic [gpfr_pkg::STRETCH_W-1:0] stretchLimit;
  logic stretchDone;
  logic [PIN_W-1:0] aOutD;
  logic [PIN_W-1:0] aOeD;
  logic [PIN_W-1:0] cOutD;
  logic [PIN_W-1:0] cOeD;
  logic [2:0] strapSync;
  gpfr_pkg::gpfr_mode_type modeD;
  logic [gpfr_pkg::DIV_W-1:0] busDiv_q;
  logic [gpfr_pkg::DIV_W-1:0] busDiv_d;
  logic [gpfr_pkg::DIV_W-1:0] refDiv_q;
  logic [gpfr_pkg::DIV_W-1:0] refDiv_d;
  logic busWrap;
  logic refWrap;

  genvar i;
  generate
    for (i = 0; i < PIN_W; i++)
    begin : g_sync
      gpfr_sync3 u_sync_a
      (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(portAPinIn[i]),
        .syncOut(portASync[i])
      );
      gpfr_sync3 u_sync_c
      (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(portCPinIn[i]),
        .syncOut(portCSync[i])
      );
      wire logic [2:0] selA = portASel[i*gpfr_pkg::SEL_W +: gpfr_pkg::SEL_W];
      wire logic [2:0] selC = portCSel[i*gpfr_pkg::SEL_W +: gpfr_pkg::SEL_W];
      wire logic useAAlt = (selA != gpfr_pkg::SEL_GPIO);
      wire logic useCAlt = (selC != gpfr_pkg::SEL_GPIO);
      assign aOutD[i] = useAAlt ? portAAltOut[i] : portAGpioOut[i]; // see [R10]
      assign aOeD[i] = useAAlt ? portAAltOe[i] : portAGpioOe[i]; // see [R10]
      if (i == gpfr_pkg::RST_PIN_IDX)
      begin : g_rst
        wire logic isRst = (selC == gpfr_pkg::SEL_RESET);
        // Active-low reset output while chip is held or stretching
        assign cOutD[i] = isRst ? !(chipInReset || !stretchDone) : // see [R4]
                          (useCAlt ? portCAltOut[i] : portCGpioOut[i]);
        assign cOeD[i] = isRst ? 1'b1 : (useCAlt ? portCAltOe[i] : portCGpioOe[i]);
      end
      else
      begin : g_norm
        wire logic cIsIrq = (selC == gpfr_pkg::SEL_IRQ);
        assign cOutD[i] = useCAlt ? portCAltOut[i] : portCGpioOut[i]; // see [R10]
        assign cOeD[i] = cIsIrq ? 1'b0 : (useCAlt ? portCAltOe[i] : portCGpioOe[i]); // see [R5]
      end
    end
  endgenerate

  generate
    for (i = 0; i < 3; i++)
    begin : g_strap
      wire logic strapIn = (i == 0) ? pll_test_strap_n :
                           ((i == 1) ? selftest_strap_n : scan_strap_n);
      gpfr_sync3 u_sync_s
      (
        .clk(clk),
        .rst_b(rst_b),
        // Inverted so the reset value of the flops means no strap asserted
        .asyncIn(!strapIn),
        .syncOut(strapSync[i])
      );
    end
  endgenerate

  // Strap decode, scan highest priority; synced straps are active high
  assign modeD = strapSync[2] ? gpfr_pkg::MODE_SCAN : // see [R9]
                 (strapSync[1] ? gpfr_pkg::MODE_SELFTEST :
                 (strapSync[0] ? gpfr_pkg::MODE_PLL_TEST : gpfr_pkg::MODE_FUNCTIONAL));

  // Stretch length depends on PLL use
  assign stretchLimit = pllEnable ? gpfr_pkg::STRETCH_W'(PLL_LOCK_COUNT) : // see [R2]
                        gpfr_pkg::STRETCH_W'(STRETCH_COUNT); // see [R1]
  assign stretchDone = (stretch_q >= stretchLimit);
  assign stretch_d = stretchDone ? stretch_q : stretch_q + 1'b1;

  // Bus and reference rates as one-cycle enables of the single clock
  assign busWrap = (busDiv_q == gpfr_pkg::DIV_W'(gpfr_pkg::BUS_CLK_DIV - 1)); // see [R8]
  assign refWrap = (refDiv_q == gpfr_pkg::DIV_W'(gpfr_pkg::REF_CLK_DIV - 1)); // see [R8]
  assign busDiv_d = busWrap ? '0 : busDiv_q + 1'b1;
  assign refDiv_d = refWrap ? '0 : refDiv_q + 1'b1;

  // Reset state and stretch counter
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      stretch_q <= '0; // see [R1]
      chipInReset <= 1'b1; // see [R4]
    end
    else
    begin
      stretch_q <= stretch_d;
      chipInReset <= 1'b0;
    end
  end

  // Port A drive
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      portAPinOut <= '0;
      portAPinOe <= '0;
    end
    else
    begin
      portAPinOut <= aOutD;
      portAPinOe <= aOeD;
    end
  end

  // Port C drive, reset pin left as an active output by reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      portCPinOut <= '0; // see [R3]
      portCPinOe <= PIN_W'(gpfr_pkg::RST_PORTC_OE); // see [R3]
    end
    else
    begin
      portCPinOut <= cOutD;
      portCPinOe <= cOeD;
    end
  end

  // Synchronised pin levels and level interrupts
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      portAIn <= '0;
      portCIn <= '0;
      level_irq_pins <= '0;
    end
    else
    begin
      portAIn <= portASync;
      portCIn <= portCSync;
      level_irq_pins <= portCSync[gpfr_pkg::LIRQ_COUNT-1:0]; // see [R5] see [R7]
    end
  end

  // Chip mode from the straps
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      chipMode <= gpfr_pkg::MODE_FUNCTIONAL;
    end
    else
    begin
      chipMode <= modeD; // see [R9]
    end
  end

  // Rate dividers for the bus and reference domains
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      busDiv_q <= '0;
      refDiv_q <= '0;
      busTick <= 1'b0;
      refTick <= 1'b0;
    end
    else
    begin
      busDiv_q <= busDiv_d;
      refDiv_q <= refDiv_d;
      busTick <= busWrap; // see [R8]
      refTick <= refWrap; // see [R8]
    end
  end
endmodule
`default_nettype wire

// *** verification/gpfr_board_model.sv ***
// Board logic on port C pins, pull-ups on idle pins
`timescale 1ns/100ps
`default_nettype none
module gpfr_board_model
(
  input wire logic [3:0] irqLevel,
  output logic [7:0] pinLevel
);
  assign pinLevel = {4'hf, irqLevel};
endmodule
`default_nettype wire

// *** verification/gpfr_pin_mux_checker.sv ***
// Assertions on the pin mux ports
`timescale 1ns/100ps
`default_nettype none
module gpfr_pin_mux_checker
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pllEnable,
  input wire logic pll_test_strap_n,
  input wire logic selftest_strap_n,
  input wire logic scan_strap_n,
  input wire logic [23:0] portASel,
  input wire logic [23:0] portCSel,
  input wire logic [7:0] portAGpioOut,
  input wire logic [7:0] portAAltOut,
  input wire logic [7:0] portCPinIn,
  input wire logic [7:0] portAPinOut,
  input wire logic [7:0] portCPinOut,
  input wire logic [7:0] portCPinOe,
  input wire logic [3:0] level_irq_pins,
  input wire logic chipInReset,
  input wire logic [1:0] chipMode,
  input wire logic busTick,
  input wire logic refTick
);
  wire [2:0] straps = {pll_test_strap_n, selftest_strap_n, scan_strap_n};
  wire [1:0] expMode = !scan_strap_n ? 2'h3 : !selftest_strap_n ? 2'h2 :
    !pll_test_strap_n ? 2'h1 : 2'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence relOff;
    $rose(rst_b) && !pllEnable && portCSel[14:12] == 3'h6;
  endsequence
  sequence relPll;
    $rose(rst_b) && pllEnable && portCSel[14:12] == 3'h6;
  endsequence
  sequence lowLong;
    !portCPinIn[0] [*7] ##1 portCPinIn[0];
  endsequence
  sequence refGap;
    !refTick [*3] ##1 refTick;
  endsequence
  a_reset_drive:
    assert property (disable iff (1'b0) !rst_b |=> chipInReset && portCPinOe == 8'h10
      && portCPinOut == 8'h00) else $error("reset pin drive wrong");
  a_release_clear:
    assert property ($rose(rst_b) |=> !chipInReset) else $error("reset flag stuck");
  // Counts match the bench's shortened stretches of 8 and 16 cycles
  a_stretch_off:
    assert property (relOff |=> !portCPinOut[4] [*8] ##1 portCPinOut[4])
      else $error("short stretch wrong");
  a_stretch_pll:
    assert property (relPll |=> !portCPinOut[4] [*8] ##1 !portCPinOut[4] [*8]
      ##1 portCPinOut[4]) else $error("lock stretch wrong");
  a_irq_follow:
    assert property ($stable(portCPinIn[3:0]) [*7] |-> level_irq_pins == portCPinIn[3:0])
      else $error("irq level wrong");
  a_irq_sync:
    assert property (lowLong |=> !level_irq_pins[0] [*4]) else $error("irq not synced");
  a_mode_decode:
    assert property ($stable(straps) [*7] |-> chipMode == expMode) else $error("mode wrong");
  a_gpio_route:
    assert property (portASel[2:0] == 3'h0 |=> portAPinOut[0] == $past(portAGpioOut[0]))
      else $error("gpio route wrong");
  a_bus_tick:
    assert property (busTick |=> !busTick ##1 busTick) else $error("bus tick period wrong");
  a_ref_tick:
    assert property ($rose(rst_b) || refTick |=> refGap) else $error("ref tick period wrong");
  a_alt_route:
    assert property (portASel[2:0] inside {[3'h1:3'h4]} |=> portAPinOut[0] ==
      $past(portAAltOut[0])) else $error("alt route wrong");
endmodule
bind gpfr_pin_mux gpfr_pin_mux_checker chk_u (.*);
`default_nettype wire

// *** verification/gpfr_pin_mux_bench.sv ***
// Self-checking bench for the pin mux
`timescale 1ns/100ps
`default_nettype none
module gpfr_pin_mux_bench;
  logic clk = 0, rst_b = 0, pllEn = 0, g = 0, a = 0;
  logic [2:0] strapN = 3'h7;
  logic [3:0] irqLvl = 4'h0, irq;
  logic [7:0] pinC, aOut, aOe, cOut, cOe, aIn, cIn;
  logic [23:0] aSel = 24'h0, cSel = 24'h006005;
  logic inRst, busTk, refTk;
  logic [1:0] mode;
  int failures = 0, checks = 0;
  int nBus = 0, nRef = 0;
  logic [5:0] rows [6] = '{6'h05, 6'h02, 6'h0b, 6'h14, 6'h1b, 6'h24};
  logic [4:0] modes [5] = '{5'h1c, 5'h0d, 5'h16, 5'h1b, 5'h03};
  initial
  begin
    forever #50 clk = ~clk;
  end
  gpfr_board_model brd_u (.irqLevel(irqLvl), .pinLevel(pinC));
  gpfr_pin_mux #(.STRETCH_COUNT(8), .PLL_LOCK_COUNT(16)) dut_u (.clk(clk), .rst_b(rst_b),
    .pllEnable(pllEn), .pll_test_strap_n(strapN[2]), .selftest_strap_n(strapN[1]),
    .scan_strap_n(strapN[0]), .portASel(aSel), .portCSel(cSel), .portAGpioOut({8{g}}),
    .portAGpioOe({8{g}}), .portAAltOut({8{a}}), .portAAltOe({8{a}}), .portCGpioOut({8{g}}),
    .portCGpioOe({8{g}}), .portCAltOut({8{a}}), .portCAltOe({8{a}}), .portAPinIn(pinC),
    .portCPinIn(pinC), .portAPinOut(aOut), .portAPinOe(aOe), .portCPinOut(cOut),
    .portCPinOe(cOe), .portAIn(aIn), .portCIn(cIn), .level_irq_pins(irq), .chipInReset(inRst),
    .chipMode(mode), .busTick(busTk), .refTick(refTk));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: value mismatch", $time);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task finish_test;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    cyc(5);
    rst_b = 1;
    for (int i = 0; i < 6; i++)
    begin
      {aSel[2:0], g, a} = rows[i][5:1];
      cyc(2);
      check(aOut[0], rows[i][0]);
      check(aOe[0], rows[i][0]);
    end
    for (int i = 0; i < 20; i++)
    begin
      cyc(1);
      nBus += busTk;
      nRef += refTk;
    end
    check(8'(nBus), 8'(20 / gpfr_pkg::BUS_CLK_DIV));
    check(8'(nRef), 8'(20 / gpfr_pkg::REF_CLK_DIV));
    for (int i = 0; i < 5; i++)
    begin
      strapN = modes[i][4:2];
      cyc(8);
      check(mode, modes[i][1:0]);
    end
    rst_b = 0;
    cyc(5);
    check(inRst, 8'h1);
    check(cOe, 8'h10);
    check(cOut, 8'h00);
    rst_b = 1;
    cyc(6);
    check(cOut[4], 8'h0);
    cyc(8);
    check({cOut[4], inRst}, 2'h2);
    rst_b = 0;
    pllEn = 1;
    cyc(2);
    rst_b = 1;
    cyc(12);
    check(cOut[4], 8'h0);
    cyc(10);
    check(cOut[4], 8'h1);
    check(cOe[0], 8'h0);
    irqLvl = 4'h5;
    cyc(7);
    check(irq, 4'h5);
    cyc(20);
    check(irq, 4'h5);
    irqLvl = 4'h0;
    cyc(7);
    check(irq, 4'h0);
    check(aIn, 8'hf0);
    check(cIn, 8'hf0);
    finish_test();
  end
endmodule
`default_nettype wire
